// >>> rtl/sfp_pkg.sv
// Shared constants and types for the serial flash port and protection block.
package sfp_pkg;
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] OP_RDSR_LO = 8'h05;
  localparam logic [7:0] OP_RDSR_HI = 8'h35;
  localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_DOUT = 8'h3b;
  localparam logic [7:0] OP_QOUT = 8'h6b;
  localparam logic [7:0] OP_DIO = 8'hbb;
  localparam logic [7:0] OP_QIO = 8'heb;
  localparam logic [7:0] OP_QWORD = 8'he7;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hd8;
  localparam logic [7:0] OP_CE1 = 8'h60;
  localparam logic [7:0] OP_CE2 = 8'hc7;
  localparam logic [7:0] OP_DP = 8'hb9;
  localparam logic [7:0] OP_RDP = 8'hab;
  localparam int ADDR_W = 21;
  localparam logic [21:0] SPAN = 22'h200000;
  localparam logic [1:0] LG_X1 = 2'h0;
  localparam logic [1:0] LG_X2 = 2'h1;
  localparam logic [1:0] LG_X4 = 2'h2;
  localparam logic [4:0] CLK_BYTE = 5'h08;
  localparam logic [4:0] CLK_ADDR = 5'h18;
  localparam logic [4:0] LOG_PAGE = 5'h08;
  localparam logic [4:0] LOG_SECT = 5'h0c;
  localparam logic [4:0] LOG_B32 = 5'h0f;
  localparam logic [4:0] LOG_B64 = 5'h10;
  localparam logic [4:0] LOG_ALL = 5'h15;
  localparam logic [4:0] LOG_BLK_BASE = 5'h0f;
  localparam logic [4:0] LOG_SUB_BASE = 5'h0b;
  localparam logic [2:0] SUB_MAX = 3'h4;
  localparam int HI_CMP = 6;
  localparam int HI_QE = 1;
  localparam int LO_PROT_LSB = 2;
  localparam logic [5:0] SYNC_RST = 6'h20;
  typedef enum logic [2:0] {
    PH_CMD = 3'b000,
    PH_ADDR = 3'b001,
    PH_DUMMY = 3'b011,
    PH_DATA = 3'b010,
    PH_IGNORE = 3'b110
  } sfp_phase_t;
  typedef enum logic [1:0] {ER_SECT, ER_B32, ER_B64, ER_CHIP} sfp_erase_t;
endpackage

// >>> rtl/sfp_core.sv
// Serial flash link front end with write enable latch and array protection.
`timescale 1ns/1ps
// Function
// (RULE1) Host uses clock mode 0 or 3; both work with the device.
// (RULE2) Input bits taken on clock rise, output bits launched on clock fall.
// (RULE3) Dual read commands use lines 0 and 1, two bits per clock.
// (RULE4) Quad read commands use lines 0 to 3, four bits per clock.
// (RULE5) Quad commands are honoured only while the quad enable bit is set.
// (RULE6) Pause stops only the link; array operations keep running.
// (RULE7) Pause starts on pause pin low, only while link clock is low.
// (RULE8) Pause ends on pause pin high, only while link clock is low.
// (RULE9) While paused the output floats and clock and input are ignored.
// (RULE10) Chip select high during pause resets the interface logic.
// (RULE11) Host releases pause before selecting the chip again.
// (RULE12) Write enable command sets the write enable latch.
// (RULE13) Latch clears on reset, write disable, status write, program, erase.
// (RULE14) Protected region stays readable but program and erase are refused.
// (RULE15) Write protect low with status protect set locks protection bits.
// (RULE16) In deep power-down only the release command is accepted.
// (RULE17) Protect field decodes to none, all, or a top or bottom range.
// (RULE18) Status write, program and erase are refused while the latch is clear.
// (RULE19) Without quad enable, lines 2 and 3 act as protect and pause pins.
// (RULE20) A refused protected operation leaves the array and later commands alone.
module sfp_core
  import sfp_pkg::*;
#(
  parameter logic [4:0] DUMMY_FAST = 5'h08,
  parameter logic [4:0] DUMMY_DIO = 5'h04,
  parameter logic [4:0] DUMMY_QIO = 5'h06,
  parameter logic [4:0] DUMMY_QWORD = 5'h04
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic [3:0] dataLineIn,
  output logic [3:0] dataLineOut,
  output logic [3:0] dataLineOeN,
  input wire logic busy,
  input wire logic [7:0] readByte,
  output logic [sfp_pkg::ADDR_W-1:0] memAddr,
  output logic [7:0] wrData,
  output logic wrStrobe,
  output logic programReq,
  output logic eraseReq,
  output logic [1:0] eraseKind,
  output logic protectReject,
  output logic writeEnableLatch,
  output logic [4:0] protectBits,
  output logic statusProtectBit,
  output logic quadEnableBit,
  output logic complementBit,
  output logic deepPowerDown,
  output logic holdActive
);
  import sfp_pkg::*;

  // ----------------------------------------
  // Decode functions.
  // ----------------------------------------
  function automatic logic opHasAddr(input logic [7:0] op);
    opHasAddr = op inside {OP_READ, OP_FAST, OP_DOUT, OP_QOUT, OP_DIO, OP_QIO, OP_QWORD,
                           OP_PP, OP_SE, OP_BE32, OP_BE64};
  endfunction

  function automatic logic [1:0] opAddrLg(input logic [7:0] op);
    opAddrLg = (op == OP_DIO) ? LG_X2 : (op inside {OP_QIO, OP_QWORD}) ? LG_X4 : LG_X1;
  endfunction

  function automatic logic [1:0] opDataLg(input logic [7:0] op);
    opDataLg = (op inside {OP_DOUT, OP_DIO}) ? LG_X2 :
               (op inside {OP_QOUT, OP_QIO, OP_QWORD}) ? LG_X4 : LG_X1;
  endfunction

  function automatic logic [4:0] opDummy(input logic [7:0] op);
    opDummy = (op inside {OP_FAST, OP_DOUT, OP_QOUT}) ? DUMMY_FAST :
              (op == OP_DIO) ? DUMMY_DIO : (op == OP_QIO) ? DUMMY_QIO :
              (op == OP_QWORD) ? DUMMY_QWORD : 5'h00;
  endfunction

  function automatic logic [4:0] opLog(input logic [7:0] op);
    opLog = (op == OP_PP) ? LOG_PAGE : (op == OP_SE) ? LOG_SECT :
            (op == OP_BE32) ? LOG_B32 : (op == OP_BE64) ? LOG_B64 : LOG_ALL;
  endfunction

  function automatic logic [23:0] shiftIn(input logic [23:0] s, input logic [1:0] lg,
                                          input logic [3:0] d);
    unique case (lg)
      LG_X1: shiftIn = {s[22:0], d[0]};
      LG_X2: shiftIn = {s[21:0], d[1:0]};
      LG_X4: shiftIn = {s[19:0], d};
      default: shiftIn = s;
    endcase
  endfunction

  function automatic logic protHit(input logic [4:0] bp, input logic c,
                                   input logic [20:0] s, input logic [20:0] e);
    logic [2:0] n;
    logic [4:0] lg;
    logic [21:0] sz;
    logic [21:0] lo;
    logic [21:0] hi;
    n = (bp[4] && bp[2:0] > SUB_MAX) ? SUB_MAX : bp[2:0];
    lg = bp[4] ? LOG_SUB_BASE + 5'(n) : LOG_BLK_BASE + 5'(n);
    sz = 22'h1 << lg;
    lo = bp[3] ? 22'h0 : SPAN - sz;
    hi = bp[3] ? sz - 22'h1 : SPAN - 22'h1;
    if (c) protHit = 1'b1;
    else if (bp[2:0] == 3'h0) protHit = 1'b0;
    else if (bp[2:1] == 2'b11) protHit = 1'b1;
    else protHit = ({1'b0, s} <= hi) && ({1'b0, e} >= lo);
  endfunction

  // ----------------------------------------
  // Pin synchronisers and edge detection.
  // ----------------------------------------
  logic [5:0] sync1_r, sync2_r;
  logic sclkPrev_r, csPrev_r, hold_r;
  wire csS = sync2_r[5];
  wire sclkS = sync2_r[4];
  wire [3:0] dIn = sync2_r[3:0];
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
      sclkPrev_r <= 1'b0;
      csPrev_r <= 1'b1;
    end else begin
      sync1_r <= {csN, sclk, dataLineIn};
      sync2_r <= sync1_r;
      sclkPrev_r <= sclkS;
      csPrev_r <= csS;
    end
  end
  wire sclkRise = sclkS & ~sclkPrev_r; // RULE1
  wire sclkFall = ~sclkS & sclkPrev_r;
  wire csRise = csS & ~csPrev_r;
  wire rxEdge = ~csS & ~hold_r & sclkRise; // RULE2 RULE9
  wire txEdge = ~csS & ~hold_r & sclkFall; // RULE2 RULE9

  // ----------------------------------------
  // Status bits and pin roles.
  // ----------------------------------------
  logic wel_r, srp_r, qe_r, cmp_r, pd_r;
  logic [4:0] bp_r;
  wire holdPinN = dIn[3] | qe_r; // RULE19
  wire hwProt = srp_r & ~dIn[2] & ~qe_r; // RULE15 RULE19
  wire [7:0] statusLo = {srp_r, bp_r, wel_r, busy};
  wire [7:0] statusHi = {1'b0, cmp_r, 4'h0, qe_r, 1'b0};

  // ----------------------------------------
  // Pause control.
  // ----------------------------------------
  // Array work driven by busy is untouched by the pause. RULE6
  always_ff @(posedge clk) begin
    if (rst || csS) hold_r <= 1'b0; // RULE10
    else if (!hold_r && !holdPinN && !sclkS) hold_r <= 1'b1; // RULE7
    else if (hold_r && holdPinN && !sclkS) hold_r <= 1'b0; // RULE8
  end

  // ----------------------------------------
  // Receive sequencer.
  // ----------------------------------------
  sfp_phase_t phase_r;
  logic [4:0] cnt_r;
  logic [1:0] lg_r, byteCnt_r;
  logic [23:0] sr_r;
  logic [7:0] cmd_r, loByte_r, hiByte_r, wrData_r;
  logic [20:0] addr_r;
  logic done_r, wrStrobe_r;
  wire [23:0] srNext = shiftIn(sr_r, lg_r, dIn);
  wire [7:0] cmdByte = srNext[7:0];
  wire cntLast = (cnt_r == 5'h01);
  wire isQuad = cmdByte inside {OP_QOUT, OP_QIO, OP_QWORD};
  wire cmdOk = pd_r ? (cmdByte == OP_RDP) : // RULE16
               busy ? (cmdByte inside {OP_RDSR_LO, OP_RDSR_HI}) : (!isQuad || qe_r); // RULE5
  wire [1:0] addrLg = opAddrLg(cmdByte); // RULE3 RULE4
  wire [1:0] dataLgR = opDataLg(cmd_r); // RULE3 RULE4
  wire [4:0] dummyR = opDummy(cmd_r);
  wire isEraseR = cmd_r inside {OP_SE, OP_BE32, OP_BE64};
  always_ff @(posedge clk) begin
    wrStrobe_r <= 1'b0;
    if (rst || csS) begin
      phase_r <= PH_CMD;
      cnt_r <= CLK_BYTE;
      lg_r <= LG_X1;
      done_r <= 1'b0;
      byteCnt_r <= 2'h0;
      sr_r <= 24'h0;
      if (rst) begin
        cmd_r <= 8'h00;
        addr_r <= 21'h0;
        loByte_r <= 8'h00;
        hiByte_r <= 8'h00;
        wrData_r <= 8'h00;
      end
    end else if (rxEdge) begin
      sr_r <= srNext;
      cnt_r <= cnt_r - 5'h01;
      unique case (phase_r)
        PH_CMD: if (cntLast) begin
          cmd_r <= cmdByte;
          if (!cmdOk) phase_r <= PH_IGNORE;
          else if (opHasAddr(cmdByte)) begin
            phase_r <= PH_ADDR;
            lg_r <= addrLg;
            cnt_r <= CLK_ADDR >> addrLg;
          end else if (cmdByte inside {OP_RDSR_LO, OP_RDSR_HI, OP_STATUS_WRITE_CMD}) begin
            phase_r <= PH_DATA;
            cnt_r <= CLK_BYTE;
          end else begin
            phase_r <= PH_IGNORE;
            done_r <= 1'b1;
          end
        end
        PH_ADDR: if (cntLast) begin
          addr_r <= srNext[20:0];
          if (isEraseR) begin
            phase_r <= PH_IGNORE;
            done_r <= 1'b1;
          end else if (dummyR != 5'h00) begin
            phase_r <= PH_DUMMY;
            cnt_r <= dummyR;
          end else begin
            phase_r <= PH_DATA;
            lg_r <= dataLgR;
            cnt_r <= CLK_BYTE >> dataLgR;
          end
        end
        PH_DUMMY: if (cntLast) begin
          phase_r <= PH_DATA;
          lg_r <= dataLgR;
          cnt_r <= CLK_BYTE >> dataLgR;
        end
        PH_DATA: if (cntLast) begin
          cnt_r <= CLK_BYTE;
          if (cmd_r inside {OP_STATUS_WRITE_CMD, OP_PP}) done_r <= 1'b1;
          if (cmd_r == OP_PP) begin
            wrData_r <= srNext[7:0];
            wrStrobe_r <= 1'b1;
          end
          if (byteCnt_r == 2'h0) loByte_r <= srNext[7:0];
          if (byteCnt_r == 2'h1) hiByte_r <= srNext[7:0];
          if (byteCnt_r != 2'h2) byteCnt_r <= byteCnt_r + 2'h1;
        end
        PH_IGNORE: done_r <= 1'b0;
        default: phase_r <= PH_IGNORE;
      endcase
    end
  end

  // ----------------------------------------
  // Transmit path.
  // ----------------------------------------
  logic [7:0] outSr_r;
  logic [4:0] outCnt_r;
  logic [3:0] laneOut_r, oeN_r;
  logic drive_r;
  logic [20:0] rdAddr_r;
  wire txCmd = cmd_r inside {OP_READ, OP_FAST, OP_DOUT, OP_QOUT, OP_DIO, OP_QIO, OP_QWORD,
                             OP_RDSR_LO, OP_RDSR_HI};
  wire txGo = txEdge & txCmd & (phase_r == PH_DATA);
  wire txLoad = txGo & (outCnt_r == 5'h00);
  wire addrLoad = rxEdge & (phase_r == PH_ADDR) & cntLast;
  wire [7:0] srcByte = (cmd_r == OP_RDSR_LO) ? statusLo :
                       (cmd_r == OP_RDSR_HI) ? statusHi : readByte;
  wire [7:0] txByte = txLoad ? srcByte : outSr_r;
  wire [3:0] laneW = 4'h1 << lg_r;
  wire [3:0] laneBits = (lg_r == LG_X4) ? txByte[7:4] : // RULE4
                        (lg_r == LG_X2) ? {2'b00, txByte[7:6]} : // RULE3
                        {2'b00, txByte[7], 1'b0};
  wire [3:0] laneMask = (lg_r == LG_X4) ? 4'hf : (lg_r == LG_X2) ? 4'h3 : 4'h2;
  always_ff @(posedge clk) begin
    if (rst) begin
      outSr_r <= 8'h00;
      outCnt_r <= 5'h00;
      laneOut_r <= 4'h0;
      drive_r <= 1'b0;
      rdAddr_r <= 21'h0;
    end else if (csS || phase_r != PH_DATA) begin
      drive_r <= 1'b0;
      outCnt_r <= 5'h00;
      rdAddr_r <= addrLoad ? srNext[20:0] : addr_r;
    end else if (txGo) begin
      laneOut_r <= laneBits; // RULE2
      outSr_r <= txByte << laneW;
      drive_r <= 1'b1;
      outCnt_r <= txLoad ? (CLK_BYTE >> lg_r) - 5'h01 : outCnt_r - 5'h01;
      if (txLoad && txCmd && !(cmd_r inside {OP_RDSR_LO, OP_RDSR_HI})) rdAddr_r <= rdAddr_r + 21'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) oeN_r <= 4'hf;
    else oeN_r <= (drive_r && !hold_r && !csS) ? ~laneMask : 4'hf; // RULE9
  end

  // ----------------------------------------
  // Command execution at deselect.
  // ----------------------------------------
  logic progReq_r, eraseReq_r, reject_r;
  logic [1:0] eraseKind_r;
  wire exec = csRise & done_r & ~hold_r; // RULE10
  wire [21:0] regMaskW = (22'h1 << opLog(cmd_r)) - 22'h1;
  wire [20:0] regStart = addr_r & ~regMaskW[20:0];
  wire [20:0] regEnd = addr_r | regMaskW[20:0];
  wire hit = protHit(bp_r, cmp_r, regStart, regEnd); // RULE14 RULE17
  wire isModify = cmd_r inside {OP_PP, OP_SE, OP_BE32, OP_BE64, OP_CE1, OP_CE2};
  always_ff @(posedge clk) begin
    progReq_r <= 1'b0;
    eraseReq_r <= 1'b0;
    reject_r <= 1'b0;
    if (rst) begin
      wel_r <= 1'b0; // RULE13
      bp_r <= 5'h00;
      srp_r <= 1'b0;
      qe_r <= 1'b0;
      cmp_r <= 1'b0;
      pd_r <= 1'b0;
      eraseKind_r <= ER_SECT;
    end else if (exec) begin
      if (cmd_r == OP_WRITE_ENABLE_CMD) wel_r <= 1'b1; // RULE12
      if (cmd_r == OP_WRITE_DISABLE_CMD || cmd_r == OP_STATUS_WRITE_CMD || isModify) wel_r <= 1'b0; // RULE13
      if (cmd_r == OP_STATUS_WRITE_CMD && wel_r && !hwProt) begin // RULE15 RULE18
        {srp_r, bp_r} <= loByte_r[7:LO_PROT_LSB];
        if (byteCnt_r == 2'h2) begin
          cmp_r <= hiByte_r[HI_CMP];
          qe_r <= hiByte_r[HI_QE];
        end
      end
      if (isModify && wel_r) begin // RULE18
        if (hit) reject_r <= 1'b1; // RULE20
        else if (cmd_r == OP_PP) progReq_r <= 1'b1;
        else eraseReq_r <= 1'b1;
      end
      eraseKind_r <= (cmd_r == OP_SE) ? ER_SECT : (cmd_r == OP_BE32) ? ER_B32 :
                     (cmd_r == OP_BE64) ? ER_B64 : ER_CHIP;
      if (cmd_r == OP_DP) pd_r <= 1'b1; // RULE16
      if (cmd_r == OP_RDP) pd_r <= 1'b0; // RULE16
    end
  end

  // ----------------------------------------
  // Outputs.
  // ----------------------------------------
  assign dataLineOut = laneOut_r;
  assign dataLineOeN = oeN_r;
  assign memAddr = rdAddr_r;
  assign wrData = wrData_r;
  assign wrStrobe = wrStrobe_r;
  assign programReq = progReq_r;
  assign eraseReq = eraseReq_r;
  assign eraseKind = eraseKind_r;
  assign protectReject = reject_r;
  assign writeEnableLatch = wel_r;
  assign protectBits = bp_r;
  assign statusProtectBit = srp_r;
  assign quadEnableBit = qe_r;
  assign complementBit = cmp_r;
  assign deepPowerDown = pd_r;
  assign holdActive = hold_r;

  // ----------------------------------------
  // Assertions.
  // ----------------------------------------
  wire cmdEnd = rxEdge & (phase_r == PH_CMD) & cntLast;
  wire allHit = protHit(bp_r, cmp_r, 21'h0, 21'h1fffff);
  property p_launch; // RULE2
    @(posedge clk) disable iff (rst) $changed(laneOut_r) |-> $past(txEdge);
  endproperty
  a_launch: assert property (p_launch) else $error("Output lane changed off a falling edge."); // RULE2
  property p_holdFloat; // RULE9
    @(posedge clk) disable iff (rst) hold_r ##1 hold_r |-> dataLineOeN == 4'hf;
  endproperty
  a_holdFloat: assert property (p_holdFloat) else $error("Output driven while paused."); // RULE9
  property p_holdEnter; // RULE7
    @(posedge clk) disable iff (rst) $rose(hold_r) |-> !$past(sclkS) && !$past(holdPinN);
  endproperty
  a_holdEnter: assert property (p_holdEnter) else $error("Pause began with clock high."); // RULE7
  property p_holdExit; // RULE8
    @(posedge clk) disable iff (rst) $fell(hold_r) && !$past(csS) |-> !$past(sclkS);
  endproperty
  a_holdExit: assert property (p_holdExit) else $error("Pause ended with clock high."); // RULE8
  property p_csReset; // RULE10
    @(posedge clk) disable iff (rst) csS |=> !hold_r && phase_r == PH_CMD;
  endproperty
  a_csReset: assert property (p_csReset) else $error("Deselect did not reset interface."); // RULE10
  property p_write_enable_cmd; // RULE12
    @(posedge clk) disable iff (rst) exec && cmd_r == OP_WRITE_ENABLE_CMD |=> wel_r ##1 wel_r || $past(exec);
  endproperty
  a_write_enable_cmd: assert property (p_write_enable_cmd) else $error("Write enable did not set latch."); // RULE12
  property p_welClear; // RULE13
    @(posedge clk) disable iff (rst) exec && (isModify || cmd_r == OP_WRITE_DISABLE_CMD) |=> !wel_r;
  endproperty
  a_welClear: assert property (p_welClear) else $error("Latch not cleared."); // RULE13
  property p_noWel; // RULE18
    @(posedge clk) disable iff (rst) exec && !wel_r |=> !programReq && !eraseReq && $stable(bp_r);
  endproperty
  a_noWel: assert property (p_noWel) else $error("Modify accepted with latch clear."); // RULE18
  property p_hwLock; // RULE15
    @(posedge clk) disable iff (rst) exec && hwProt |=> $stable(bp_r) && $stable(srp_r);
  endproperty
  a_hwLock: assert property (p_hwLock) else $error("Protect bits changed while locked."); // RULE15
  property p_quadGate; // RULE5
    @(posedge clk) disable iff (rst) cmdEnd && isQuad && !qe_r |=> phase_r == PH_IGNORE;
  endproperty
  a_quadGate: assert property (p_quadGate) else $error("Quad command taken without enable."); // RULE5
  property p_pdGate; // RULE16
    @(posedge clk) disable iff (rst) cmdEnd && pd_r && cmdByte != OP_RDP |=> phase_r == PH_IGNORE;
  endproperty
  a_pdGate: assert property (p_pdGate) else $error("Command taken in power-down."); // RULE16
  property p_protMap; // RULE17
    @(posedge clk) disable iff (rst) !cmp_r |-> (bp_r[2:0] == 3'h0 |-> !allHit) and
      (bp_r[2:1] == 2'b11 |-> protHit(bp_r, cmp_r, 21'h0, 21'h0));
  endproperty
  a_protMap: assert property (p_protMap) else $error("Protect field decoded wrongly."); // RULE17
  property p_protReject; // RULE20
    @(posedge clk) disable iff (rst) exec && isModify && wel_r && hit |=>
      protectReject && !programReq && !eraseReq;
  endproperty
  a_protReject: assert property (p_protReject) else $error("Protected modify not refused."); // RULE20
endmodule // sfp_core

// >>> testbench/sfp_host_model.sv
// Behavioural serial bus host that drives the flash link in clock mode 0.
`timescale 1ns/1ps
module sfp_host_model (
  input wire logic clk,
  input wire logic [3:0] lineLvl,
  output logic csN,
  output logic sclk,
  output logic [3:0] hostLine
);
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    hostLine = 4'hf;
  end
  task automatic select();
    @(posedge clk) csN <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk) hostLine[0] <= tx[i];
      repeat (3) @(posedge clk);
      @(posedge clk) sclk <= 1'b1;
      @(posedge clk) rx[i] = lineLvl[1];
      repeat (2) @(posedge clk);
      @(posedge clk) sclk <= 1'b0;
    end
  endtask
  task automatic deselect();
    repeat (4) @(posedge clk);
    @(posedge clk) begin
      csN <= 1'b1;
      hostLine[0] <= ~hostLine[0];
    end
    repeat (8) @(posedge clk);
  endtask
endmodule // sfp_host_model

// >>> testbench/test_sfp_core.sv
// Self-checking testbench for the serial flash port and protection block.
`timescale 1ns/1ps
module test_sfp_core;
  import sfp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic busy = 1'b0;
  logic csN;
  logic sclk;
  logic [3:0] hostLine;
  logic [3:0] lineLvl;
  logic [3:0] dataLineOut;
  logic [3:0] dataLineOeN;
  logic [3:0] oeSeen;
  logic [ADDR_W-1:0] memAddr;
  logic [7:0] wrData;
  logic [7:0] rdByte;
  logic [7:0] arrayByte;
  logic [1:0] eraseKind;
  logic [4:0] protectBits;
  logic wrStrobe, programReq, eraseReq, protectReject, writeEnableLatch;
  logic statusProtectBit, quadEnableBit, complementBit, deepPowerDown, holdActive;
  int failures = 0;
  int total_checks = 0;
  int goodCnt = 0;
  int rejCnt = 0;
  logic [47:0] tbl [6] = '{{OP_SE, 8'h04, 24'h1f0000, 8'h1}, {OP_SE, 8'h04, 24'h1ef000, 8'h0},
    {OP_PP, 8'h64, 24'h000100, 8'h1}, {OP_SE, 8'h64, 24'h001000, 8'h0},
    {OP_SE, 8'h18, 24'h000000, 8'h1}, {OP_PP, 8'h00, 24'h1fff00, 8'h0}};
  always #10 clk = ~clk;
  assign lineLvl = (~dataLineOeN & dataLineOut) | (dataLineOeN & hostLine);
  assign arrayByte = memAddr[7:0] ^ 8'h5a;
  always @(posedge clk) begin
    if (programReq === 1'b1 || eraseReq === 1'b1) goodCnt++;
    if (protectReject === 1'b1) rejCnt++;
  end
  sfp_core u_sfp_core (.clk(clk), .rst(rst), .csN(csN), .sclk(sclk), .dataLineIn(lineLvl),
    .dataLineOut(dataLineOut), .dataLineOeN(dataLineOeN), .busy(busy), .readByte(arrayByte),
    .memAddr(memAddr), .wrData(wrData), .wrStrobe(wrStrobe), .programReq(programReq),
    .eraseReq(eraseReq), .eraseKind(eraseKind), .protectReject(protectReject),
    .writeEnableLatch(writeEnableLatch), .protectBits(protectBits),
    .statusProtectBit(statusProtectBit), .quadEnableBit(quadEnableBit),
    .complementBit(complementBit), .deepPowerDown(deepPowerDown), .holdActive(holdActive));
  sfp_host_model u_sfp_host_model (.clk(clk), .lineLvl(lineLvl), .csN(csN), .sclk(sclk),
    .hostLine(hostLine));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [39:0] w, input int n, input int extra);
    u_sfp_host_model.select();
    for (int k = n - 1; k >= 0; k--) u_sfp_host_model.xfer(w[8*k +: 8], rdByte);
    for (int k = 0; k < extra; k++) u_sfp_host_model.xfer(8'h00, rdByte);
    oeSeen = dataLineOeN;
    u_sfp_host_model.deselect();
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    complete_run();
  end
  initial begin
    int g0;
    int r0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    check(writeEnableLatch, 1'b0);
    cmd({32'h0, OP_WRITE_ENABLE_CMD}, 1, 0);
    check(writeEnableLatch, 1'b1);
    cmd({32'h0, OP_WRITE_DISABLE_CMD}, 1, 0);
    check(writeEnableLatch, 1'b0);
    cmd({24'h0, OP_STATUS_WRITE_CMD, 8'h04}, 2, 0);
    check(protectBits, 5'h00);
    $display("test latch done");
    foreach (tbl[i]) begin
      cmd({32'h0, OP_WRITE_ENABLE_CMD}, 1, 0);
      cmd({24'h0, OP_STATUS_WRITE_CMD, tbl[i][39:32]}, 2, 0);
      check(protectBits, tbl[i][38:34]);
      check(writeEnableLatch, 1'b0);
      g0 = goodCnt;
      r0 = rejCnt;
      cmd({32'h0, OP_WRITE_ENABLE_CMD}, 1, 0);
      if (tbl[i][47:40] == OP_PP) cmd({tbl[i][47:40], tbl[i][31:8], 8'ha5}, 5, 0);
      else cmd({8'h0, tbl[i][47:40], tbl[i][31:8]}, 4, 0);
      check(rejCnt - r0, {24'h0, tbl[i][7:0]});
      check(goodCnt - g0, {24'h0, ~tbl[i][7:0]} & 32'h1);
      check(writeEnableLatch, 1'b0);
    end
    check(wrData, 8'ha5);
    $display("test protect done");
    cmd({OP_READ, 24'h000010, 8'h0}, 5, 0);
    check(rdByte, 8'h4a);
    cmd({OP_READ, 24'h000010, 8'h0}, 5, 1);
    check(rdByte, 8'h4b);
    cmd({8'h0, OP_QOUT, 24'h000010}, 4, 2);
    check(oeSeen, 4'hf);
    cmd({8'h0, OP_DOUT, 24'h000010}, 4, 2);
    check(oeSeen, 4'hc);
    cmd({32'h0, OP_WRITE_ENABLE_CMD}, 1, 0);
    cmd({16'h0, OP_STATUS_WRITE_CMD, 16'h0002}, 3, 0);
    check(quadEnableBit, 1'b1);
    cmd({8'h0, OP_QOUT, 24'h000010}, 4, 2);
    check(oeSeen, 4'h0);
    cmd({32'h0, OP_WRITE_ENABLE_CMD}, 1, 0);
    cmd({16'h0, OP_STATUS_WRITE_CMD, 16'h0000}, 3, 0);
    $display("test read done");
    cmd({32'h0, OP_DP}, 1, 0);
    check(deepPowerDown, 1'b1);
    cmd({32'h0, OP_WRITE_ENABLE_CMD}, 1, 0);
    check(writeEnableLatch, 1'b0);
    cmd({32'h0, OP_RDP}, 1, 0);
    check(deepPowerDown, 1'b0);
    $display("test power done");
    u_sfp_host_model.select();
    u_sfp_host_model.xfer(OP_RDSR_LO, rdByte);
    @(posedge clk) u_sfp_host_model.hostLine[3] <= 1'b0;
    repeat (8) @(posedge clk);
    check(holdActive, 1'b1);
    check(dataLineOeN, 4'hf);
    @(posedge clk) u_sfp_host_model.hostLine[3] <= 1'b1;
    repeat (8) @(posedge clk);
    check(holdActive, 1'b0);
    @(posedge clk) u_sfp_host_model.hostLine[3] <= 1'b0;
    repeat (8) @(posedge clk);
    u_sfp_host_model.deselect();
    check(holdActive, 1'b0);
    @(posedge clk) u_sfp_host_model.hostLine[3] <= 1'b1;
    $display("test pause done");
    cmd({32'h0, OP_WRITE_ENABLE_CMD}, 1, 0);
    cmd({24'h0, OP_STATUS_WRITE_CMD, 8'h84}, 2, 0);
    @(posedge clk) u_sfp_host_model.hostLine[2] <= 1'b0;
    cmd({32'h0, OP_WRITE_ENABLE_CMD}, 1, 0);
    cmd({24'h0, OP_STATUS_WRITE_CMD, 8'h00}, 2, 0);
    check({statusProtectBit, protectBits}, 6'h21);
    @(posedge clk) u_sfp_host_model.hostLine[2] <= 1'b1;
    cmd({32'h0, OP_WRITE_ENABLE_CMD}, 1, 0);
    cmd({24'h0, OP_STATUS_WRITE_CMD, 8'h00}, 2, 0);
    check({statusProtectBit, protectBits}, 6'h00);
    $display("test lock done");
    complete_run();
  end
endmodule // test_sfp_core
